// File: dmp_pkg.sv
package dmp_pkg;
   // Register offsets on the plain register port
   localparam logic [3:0] DMP_OFS_DATA = 4'h0;
   localparam logic [3:0] DMP_OFS_INT_EN = 4'h1;
   localparam logic [3:0] DMP_OFS_MODEM_CTRL = 4'h2;
   localparam logic [3:0] DMP_OFS_MODEM_STAT = 4'h3;
   localparam logic [3:0] DMP_OFS_FEATURE = 4'h4;
   localparam logic [3:0] DMP_OFS_ENH_FEATURE = 4'h5;
   localparam logic [3:0] DMP_OFS_ENH_MODE = 4'h6;
   localparam logic [3:0] DMP_OFS_ALT_FUNC = 4'h7;
   localparam logic [3:0] DMP_OFS_DIV_LO = 4'h8;
   localparam logic [3:0] DMP_OFS_DIV_HI = 4'h9;
   localparam logic [3:0] DMP_OFS_EVT_STAT = 4'hA;
   localparam logic [3:0] DMP_OFS_EVT_MASK = 4'hB;
   // Field positions
   localparam int DMP_MC_DTR = 0;
   localparam int DMP_MC_RTS = 1;
   localparam int DMP_MC_USER = 3;
   localparam int DMP_MC_IR = 6;
   localparam int DMP_FC_RXINV = 2;
   localparam int DMP_FC_RS485 = 3;
   localparam int DMP_EF_AUTORTS = 6;
   localparam int DMP_EF_AUTOCTS = 7;
   localparam int DMP_IE_CTS = 7;
   localparam int DMP_EM_DIRPOL = 3;
   localparam int DMP_AF_BCAST = 0;
   localparam int DMP_AF_SEL_LO = 1;
   localparam int DMP_EV_RX = 0;
   localparam int DMP_EV_TX = 1;
   localparam int DMP_EV_CTS = 2;
   // Multi-function output selections
   localparam logic [1:0] DMP_MF_USER = 2'h0;
   localparam logic [1:0] DMP_MF_BAUD = 2'h1;
   localparam logic [1:0] DMP_MF_RXRDY = 2'h2;
   // Reset values
   localparam logic [7:0] DMP_RST_BYTE = 8'h00;
   localparam logic [15:0] DMP_RST_DIV = 16'h0001;
   // Bit timing in 16X ticks
   localparam logic [3:0] DMP_TICK_LAST = 4'hF;
   localparam logic [3:0] DMP_TICK_MID = 4'h7;
   localparam logic [3:0] DMP_IR_PULSE = 4'h3;
   localparam logic [2:0] DMP_BIT_LAST = 3'h7;
   typedef enum logic [1:0] {DMP_IDLE, DMP_START, DMP_DATA, DMP_STOP}
      dmp_frame_e;
endpackage

// File: dmp_baud_if.sv
`timescale 1ns/100ps
`default_nettype none
interface dmp_baud_if;
   logic [15:0] divisor;
   logic tick;
   logic clk16;
   modport gen (input divisor, output tick, output clk16);
   modport user (output divisor, input tick, input clk16);
endinterface // dmp_baud_if
`default_nettype wire

// File: dmp_baud_gen.sv
`timescale 1ns/100ps
`default_nettype none
module dmp_baud_gen (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_i,
   // Divisor in, 16X tick and clock out
   dmp_baud_if.gen baud
);
   import dmp_pkg::*;

   logic [15:0] cnt_reg;
   logic [15:0] cnt_next;
   logic tick_reg;
   logic clk_reg;
   wire logic [15:0] div_eff;
   wire logic wrap;

   // A zero divisor would stall the channel, so it acts as one
   assign div_eff = (baud.divisor == 16'h0000) ? DMP_RST_DIV : baud.divisor;
   assign wrap = (cnt_reg >= div_eff - DMP_RST_DIV);
   assign cnt_next = wrap ? 16'h0000 : cnt_reg + DMP_RST_DIV;

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         cnt_reg <= 16'h0000;
         tick_reg <= 1'b0;
         clk_reg <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         tick_reg <= wrap;
         clk_reg <= (cnt_reg < (div_eff >> 1));
      end
   end

   assign baud.tick = tick_reg;
   assign baud.clk16 = clk_reg;
endmodule // dmp_baud_gen
`default_nettype wire

// File: dmp_channel.sv
// What this block does
// - Multi-function output carries one selected function
// - User function: low while modem bit 3 set
// - Modem bit 3 clears at reset
// - Baud function: 16X baud clock out, held low at divisor 0 or 1
// - Receive-ready function: active-low data available
// - Standard mode: transmit high at reset, idle
// - Infrared mode: transmit rests low
// - Optional receive inversion before infrared decoder
// - RTS drives RS-485 direction, selectable polarity
// - CTS gates transmit; change raises interrupt
// - DSR, CD and RI inputs only reported, no effect
// - DTR output follows its modem bit
// - Channel select, broadcast write override
`timescale 1ns/100ps
`default_nettype none
module dmp_channel #(
   parameter bit IS_CHANNEL_A = 1'b1
) (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_i,
   // Register port
   input wire logic chip_select_n_i,
   input wire logic channel_select_i,
   input wire logic [3:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [7:0] reg_rdata_o,
   output logic irq_o,
   // Serial and modem pins
   input wire logic serial_rx_in_i,
   output logic serial_tx_out_o,
   input wire logic clear_to_send_n_i,
   output logic request_to_send_n_o,
   output logic terminal_ready_n_o,
   input wire logic set_ready_n_i,
   input wire logic carrier_detect_n_i,
   input wire logic ring_indicate_n_i,
   output logic multi_function_out_o
);
   import dmp_pkg::*;

   function automatic logic [7:0] sticky(input logic [7:0] cur,
      input logic [7:0] set, input logic [7:0] clr);
      // Set wins over a clear in the same cycle
      sticky = (cur & ~clr) | set;
   endfunction

   function automatic logic at(input logic tick, input logic [3:0] cnt,
      input logic [3:0] n);
      at = tick && (cnt == n);
   endfunction

   dmp_baud_if baud ();
   dmp_baud_gen u_baud (
      .ref_clk_i(ref_clk_i),
      .rst_i(rst_i),
      .baud(baud.gen)
   );

   logic [7:0] int_en_reg, modem_ctrl_reg, feature_reg, enh_feature_reg;
   logic [7:0] enh_mode_reg, alt_func_reg, div_lo_reg, div_hi_reg;
   logic [7:0] evt_stat_reg, evt_mask_reg, evt_stat_next;
   logic [7:0] tx_hold_reg, tx_shift_reg, rx_shift_reg, rx_data_reg;
   logic [7:0] rdata_reg;
   logic tx_full_reg, rx_ready_reg, cts_prev_reg;
   logic tx_out_reg, rts_reg, dtr_reg, mfo_reg, irq_reg;
   logic [3:0] tx_cnt_reg, rx_cnt_reg, stretch_reg;
   logic [2:0] tx_bit_reg, rx_bit_reg;
   dmp_frame_e tx_state_reg, tx_state_next, rx_state_reg, rx_state_next;

   assign baud.divisor = {div_hi_reg, div_lo_reg};

   // Access decode
   wire logic sel_match;
   wire logic wr_en;
   wire logic rd_en;
   assign sel_match = (channel_select_i == IS_CHANNEL_A);
   assign wr_en = reg_wr_i && !chip_select_n_i &&
      (sel_match || alt_func_reg[DMP_AF_BCAST]);
   assign rd_en = reg_rd_i && !chip_select_n_i && sel_match;
   wire logic wr_data = wr_en && (reg_addr_i == DMP_OFS_DATA);
   wire logic rd_data = rd_en && (reg_addr_i == DMP_OFS_DATA);
   wire logic wr_stat = wr_en && (reg_addr_i == DMP_OFS_EVT_STAT);

   wire logic ir_mode = modem_ctrl_reg[DMP_MC_IR];
   wire logic tick = baud.tick;
   wire logic [1:0] mf_sel = alt_func_reg[DMP_AF_SEL_LO +: 2];

   // Optional inversion ahead of the decoder
   wire logic rx_raw = serial_rx_in_i ^ (ir_mode & feature_reg[DMP_FC_RXINV]);
   // Each infrared pulse is held 15 ticks past its end so the decoder
   // cannot miss it between sample points
   wire logic rx_pulse = rx_raw || (stretch_reg != 4'h0);
   // Standard line relies on a high idle level
   wire logic rx_line = ir_mode ? !rx_pulse : rx_raw;

   // Transmit sequencing
   wire logic tx_busy = (tx_state_reg != DMP_IDLE);
   // Auto CTS holds off a new frame
   wire logic cts_ok = !enh_feature_reg[DMP_EF_AUTOCTS] || !clear_to_send_n_i;
   wire logic tx_launch = tx_full_reg && cts_ok && tick;
   wire logic tx_bit_end = at(tick, tx_cnt_reg, DMP_TICK_LAST);
   wire logic tx_done = (tx_state_reg == DMP_STOP) && tx_bit_end;

   always_comb begin
      tx_state_next = tx_state_reg;
      case (tx_state_reg)
         DMP_IDLE: if (tx_launch) tx_state_next = DMP_START;
         DMP_START: if (tx_bit_end) tx_state_next = DMP_DATA;
         DMP_DATA: if (tx_bit_end && tx_bit_reg == DMP_BIT_LAST)
            tx_state_next = DMP_STOP;
         DMP_STOP: if (tx_bit_end) tx_state_next = DMP_IDLE;
         default: tx_state_next = DMP_IDLE;
      endcase
   end

   wire logic tx_level = (tx_state_reg == DMP_START) ? 1'b0 :
      (tx_state_reg == DMP_DATA) ? tx_shift_reg[0] : 1'b1;
   // Standard idles high; infrared pulses zeros, rests low
   wire logic tx_pin = ir_mode ? (!tx_level && tx_cnt_reg < DMP_IR_PULSE) :
      tx_level;

   // Receive sequencing
   wire logic rx_mid = at(tick, rx_cnt_reg, DMP_TICK_MID);
   wire logic rx_bit_end = at(tick, rx_cnt_reg, DMP_TICK_LAST);
   wire logic rx_got = (rx_state_reg == DMP_STOP) && rx_bit_end && rx_line;

   always_comb begin
      rx_state_next = rx_state_reg;
      case (rx_state_reg)
         DMP_IDLE: if (tick && !rx_line) rx_state_next = DMP_START;
         DMP_START: if (rx_mid)
            rx_state_next = rx_line ? DMP_IDLE : DMP_DATA;
         DMP_DATA: if (rx_bit_end && rx_bit_reg == DMP_BIT_LAST)
            rx_state_next = DMP_STOP;
         DMP_STOP: if (rx_bit_end) rx_state_next = DMP_IDLE;
         default: rx_state_next = DMP_IDLE;
      endcase
   end

   // Events and interrupt
   wire logic cts_evt = int_en_reg[DMP_IE_CTS] &&
      (clear_to_send_n_i != cts_prev_reg);
   wire logic [7:0] evt_set = {5'h00, cts_evt, tx_done, rx_got};
   assign evt_stat_next = sticky(evt_stat_reg, evt_set,
      wr_stat ? reg_wdata_i : DMP_RST_BYTE);

   // Request-to-send selection
   // Auto RTS only drops the line; software must have raised it first
   wire logic rts_auto = enh_feature_reg[DMP_EF_AUTORTS] && rx_ready_reg;
   // Direction control while a frame is out
   wire logic rts_pin = feature_reg[DMP_FC_RS485] ?
      (tx_busy ? enh_mode_reg[DMP_EM_DIRPOL] : !enh_mode_reg[DMP_EM_DIRPOL]) :
      !(modem_ctrl_reg[DMP_MC_RTS] && !rts_auto);

   // One function on the multi-function pin
   wire logic mf_pin = (mf_sel == DMP_MF_BAUD) ? baud.clk16 :
      (mf_sel == DMP_MF_RXRDY) ? !rx_ready_reg :
      !modem_ctrl_reg[DMP_MC_USER];

   // DSR, CD and RI inputs are visible here only
   wire logic [7:0] rd_mux =
      (reg_addr_i == DMP_OFS_DATA) ? rx_data_reg :
      (reg_addr_i == DMP_OFS_INT_EN) ? int_en_reg :
      (reg_addr_i == DMP_OFS_MODEM_CTRL) ? modem_ctrl_reg :
      (reg_addr_i == DMP_OFS_MODEM_STAT) ? {!carrier_detect_n_i,
         !ring_indicate_n_i, !set_ready_n_i, !clear_to_send_n_i,
         tx_busy, tx_full_reg, 1'b0, rx_ready_reg} :
      (reg_addr_i == DMP_OFS_FEATURE) ? feature_reg :
      (reg_addr_i == DMP_OFS_ENH_FEATURE) ? enh_feature_reg :
      (reg_addr_i == DMP_OFS_ENH_MODE) ? enh_mode_reg :
      (reg_addr_i == DMP_OFS_ALT_FUNC) ? alt_func_reg :
      (reg_addr_i == DMP_OFS_DIV_LO) ? div_lo_reg :
      (reg_addr_i == DMP_OFS_DIV_HI) ? div_hi_reg :
      (reg_addr_i == DMP_OFS_EVT_STAT) ? evt_stat_reg :
      (reg_addr_i == DMP_OFS_EVT_MASK) ? evt_mask_reg : DMP_RST_BYTE;

   // Software registers
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         int_en_reg <= DMP_RST_BYTE;
         modem_ctrl_reg <= DMP_RST_BYTE;
         feature_reg <= DMP_RST_BYTE;
         enh_feature_reg <= DMP_RST_BYTE;
         enh_mode_reg <= DMP_RST_BYTE;
         alt_func_reg <= DMP_RST_BYTE;
         div_lo_reg <= DMP_RST_DIV[7:0];
         div_hi_reg <= DMP_RST_DIV[15:8];
         evt_mask_reg <= DMP_RST_BYTE;
      end else if (wr_en) begin
         case (reg_addr_i)
            DMP_OFS_INT_EN: int_en_reg <= reg_wdata_i;
            DMP_OFS_MODEM_CTRL: modem_ctrl_reg <= reg_wdata_i;
            DMP_OFS_FEATURE: feature_reg <= reg_wdata_i;
            DMP_OFS_ENH_FEATURE: enh_feature_reg <= reg_wdata_i;
            DMP_OFS_ENH_MODE: enh_mode_reg <= reg_wdata_i;
            DMP_OFS_ALT_FUNC: alt_func_reg <= reg_wdata_i;
            DMP_OFS_DIV_LO: div_lo_reg <= reg_wdata_i;
            DMP_OFS_DIV_HI: div_hi_reg <= reg_wdata_i;
            DMP_OFS_EVT_MASK: evt_mask_reg <= reg_wdata_i;
            default: ;
         endcase
      end
   end

   // Transmit datapath
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         tx_state_reg <= DMP_IDLE;
         tx_hold_reg <= DMP_RST_BYTE;
         tx_shift_reg <= DMP_RST_BYTE;
         tx_full_reg <= 1'b0;
         tx_cnt_reg <= 4'h0;
         tx_bit_reg <= 3'h0;
      end else begin
         tx_state_reg <= tx_state_next;
         if (tick) begin
            tx_cnt_reg <= tx_busy ? tx_cnt_reg + 4'h1 : 4'h0;
         end
         if (tx_state_reg == DMP_IDLE && tx_launch) begin
            tx_shift_reg <= tx_hold_reg;
            tx_bit_reg <= 3'h0;
         end else if (tx_state_reg == DMP_DATA && tx_bit_end) begin
            tx_shift_reg <= tx_shift_reg >> 1;
            tx_bit_reg <= tx_bit_reg + 3'h1;
         end
         // A write while full overwrites the waiting byte
         if (wr_data) begin
            tx_hold_reg <= reg_wdata_i;
            tx_full_reg <= 1'b1;
         end else if (tx_state_reg == DMP_IDLE && tx_launch) begin
            tx_full_reg <= 1'b0;
         end
      end
   end

   // Receive datapath
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         rx_state_reg <= DMP_IDLE;
         rx_shift_reg <= DMP_RST_BYTE;
         rx_data_reg <= DMP_RST_BYTE;
         rx_ready_reg <= 1'b0;
         rx_cnt_reg <= 4'h0;
         rx_bit_reg <= 3'h0;
         stretch_reg <= 4'h0;
      end else begin
         rx_state_reg <= rx_state_next;
         if (ir_mode && rx_raw) begin
            stretch_reg <= DMP_TICK_LAST;
         end else if (tick && stretch_reg != 4'h0) begin
            stretch_reg <= stretch_reg - 4'h1;
         end
         if (rx_state_reg == DMP_START && rx_mid) begin
            rx_cnt_reg <= 4'h0;
            rx_bit_reg <= 3'h0;
         end else if (tick) begin
            rx_cnt_reg <= (rx_state_reg == DMP_IDLE) ? 4'h0 :
               rx_cnt_reg + 4'h1;
         end
         if (rx_state_reg == DMP_DATA && rx_bit_end) begin
            rx_shift_reg <= {rx_line, rx_shift_reg[7:1]};
            rx_bit_reg <= rx_bit_reg + 3'h1;
         end
         if (rx_got) begin
            rx_data_reg <= rx_shift_reg;
         end
         rx_ready_reg <= rx_got || (rx_ready_reg && !rd_data);
      end
   end

   // Pins, status and read data
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         evt_stat_reg <= DMP_RST_BYTE;
         cts_prev_reg <= 1'b1;
         tx_out_reg <= 1'b1;
         rts_reg <= 1'b1;
         dtr_reg <= 1'b1;
         mfo_reg <= 1'b1;
         irq_reg <= 1'b0;
         rdata_reg <= DMP_RST_BYTE;
      end else begin
         evt_stat_reg <= evt_stat_next;
         cts_prev_reg <= clear_to_send_n_i;
         tx_out_reg <= tx_pin;
         rts_reg <= rts_pin;
         dtr_reg <= !modem_ctrl_reg[DMP_MC_DTR];
         mfo_reg <= mf_pin;
         irq_reg <= |(evt_stat_reg & evt_mask_reg);
         rdata_reg <= rd_en ? rd_mux : DMP_RST_BYTE;
      end
   end

   assign serial_tx_out_o = tx_out_reg;
   assign request_to_send_n_o = rts_reg;
   assign terminal_ready_n_o = dtr_reg;
   assign multi_function_out_o = mfo_reg;
   assign irq_o = irq_reg;
   assign reg_rdata_o = rdata_reg;

   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);

   a_user_out_low: assert property (
      mf_sel == DMP_MF_USER |=>
      multi_function_out_o == !$past(modem_ctrl_reg[DMP_MC_USER]))
      else $error("user output level wrong");
   a_user_bit_reset: assert property (
      $fell(rst_i) |-> !modem_ctrl_reg[DMP_MC_USER] && multi_function_out_o)
      else $error("user output active after reset");
   a_baud_clock_out: assert property (
      mf_sel == DMP_MF_BAUD |=> multi_function_out_o == $past(baud.clk16))
      else $error("baud clock not on pin");
   a_rxrdy_pin: assert property (
      mf_sel == DMP_MF_RXRDY |=>
      multi_function_out_o == !$past(rx_ready_reg))
      else $error("receive ready pin wrong");
   a_std_idle_high: assert property (
      !ir_mode && !tx_busy |=> serial_tx_out_o)
      else $error("standard idle not high");
   a_ir_idle_low: assert property (
      ir_mode && !tx_busy |=> !serial_tx_out_o)
      else $error("infrared idle not low");
   a_cts_hold_off: assert property (
      enh_feature_reg[DMP_EF_AUTOCTS] && clear_to_send_n_i && !tx_busy
      |=> !tx_busy)
      else $error("frame started without clear to send");
   a_dir_polarity: assert property (
      feature_reg[DMP_FC_RS485] && tx_busy |=>
      request_to_send_n_o == $past(enh_mode_reg[DMP_EM_DIRPOL]))
      else $error("direction output polarity wrong");
   a_dtr_follow: assert property (
      $changed(modem_ctrl_reg[DMP_MC_DTR]) |=>
      terminal_ready_n_o == !$past(modem_ctrl_reg[DMP_MC_DTR]))
      else $error("terminal ready not following bit");

   c_rx_byte: cover property (rx_got);
   c_tx_byte: cover property (tx_done);
   c_cts_evt: cover property (cts_evt ##1 irq_o);
   c_ir_frame: cover property (ir_mode && tx_done);
endmodule // dmp_channel
`default_nettype wire

// File: dmp_remote_model.sv
`timescale 1ns/100ps
`default_nettype none
module dmp_remote_model (
   // Clock
   input wire logic ref_clk_i,
   // Serial pins seen from the far end
   input wire logic tx_i,
   output logic rx_o,
   output logic cts_n_o
);
   logic idle_lvl;
   // Receive line idles high in standard mode
   initial begin
      idle_lvl = 1'b1;
      rx_o = 1'b1;
      cts_n_o = 1'b0;
   end
   task automatic set_mode(input logic ir, input logic inv);
      idle_lvl = !ir || inv;
      @(posedge ref_clk_i);
      rx_o <= idle_lvl;
   endtask
   task automatic set_cts(input logic v);
      @(posedge ref_clk_i);
      cts_n_o <= v;
   endtask
   // Infrared zero is a 3-tick pulse; one tick is one clock at divisor 1
   task automatic send_bit(input logic b, input logic ir);
      for (int i = 0; i < 16; i++) begin
         if (!ir)
            rx_o <= b;
         else
            rx_o <= (!b && i < 3) ? !idle_lvl : idle_lvl;
         @(posedge ref_clk_i);
      end
   endtask
   task automatic send(input logic [7:0] d, input logic ir);
      @(posedge ref_clk_i);
      send_bit(1'b0, ir);
      for (int i = 0; i < 8; i++)
         send_bit(d[i], ir);
      send_bit(1'b1, ir);
   endtask
   // Bounded wait for a start bit, then sample each bit mid-cell
   task automatic grab(output logic [7:0] d, output logic ok);
      int n;
      n = 0;
      d = 8'h00;
      while (tx_i !== 1'b0 && n < 4000) begin
         @(posedge ref_clk_i);
         n++;
      end
      repeat (8) @(posedge ref_clk_i);
      ok = (tx_i === 1'b0);
      for (int i = 0; i < 8; i++) begin
         repeat (16) @(posedge ref_clk_i);
         d[i] = tx_i;
      end
      repeat (16) @(posedge ref_clk_i);
      ok = ok && (tx_i === 1'b1);
   endtask
endmodule // dmp_remote_model
`default_nettype wire

// File: testbench.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, sn) begin \
   check_count++; \
   if ((sn) !== (ex)) begin \
      error_cnt++; \
      $display("Error %s expected %0h seen %0h", nm, ex, sn); \
   end \
end
module testbench;
   import dmp_pkg::*;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic cs_n = 1'b0;
   logic ch_sel = 1'b1;
   logic [3:0] addr = 4'h0;
   logic [7:0] wdata = 8'h00;
   logic wr_s = 1'b0;
   logic rd_s = 1'b0;
   logic dsr_n = 1'b1;
   logic cd_n = 1'b1;
   logic ri_n = 1'b1;
   logic [7:0] rdata;
   logic irq, rx, tx, cts_n, rts_n, dtr_n, mfo;
   logic [7:0] d;
   logic ok;
   int error_cnt = 0;
   int check_count = 0;
   int cyc = 0;
   always #5 ref_clk = !ref_clk;
   dmp_channel #(.IS_CHANNEL_A(1'b1)) dut_u (.ref_clk_i(ref_clk),
      .rst_i(rst), .chip_select_n_i(cs_n), .channel_select_i(ch_sel),
      .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr_s),
      .reg_rd_i(rd_s), .reg_rdata_o(rdata), .irq_o(irq),
      .serial_rx_in_i(rx), .serial_tx_out_o(tx), .clear_to_send_n_i(cts_n),
      .request_to_send_n_o(rts_n), .terminal_ready_n_o(dtr_n),
      .set_ready_n_i(dsr_n), .carrier_detect_n_i(cd_n),
      .ring_indicate_n_i(ri_n), .multi_function_out_o(mfo));
   dmp_remote_model rm_u (.ref_clk_i(ref_clk), .tx_i(tx), .rx_o(rx),
      .cts_n_o(cts_n));
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // Hang guard: the whole run needs well under this
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         print_verdict();
      end
   end
   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      @(posedge ref_clk);
      addr <= a;
      wdata <= v;
      wr_s <= 1'b1;
      @(posedge ref_clk);
      wr_s <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [7:0] v);
      @(posedge ref_clk);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge ref_clk);
      rd_s <= 1'b0;
      #1;
      v = rdata;
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   task automatic t_reset();
      `CHK("tx", 1'b1, tx)
      `CHK("mfo", 1'b1, mfo)
      `CHK("rts_n", 1'b1, rts_n)
      `CHK("dtr_n", 1'b1, dtr_n)
      `CHK("irq", 1'b0, irq)
      rd(DMP_OFS_MODEM_CTRL, d);
      `CHK("modem_ctrl", 8'h00, d)
      rd(DMP_OFS_DIV_LO, d);
      `CHK("div_lo", 8'h01, d)
      $display("test reset done");
   endtask
   task automatic t_user();
      wr(DMP_OFS_MODEM_CTRL, 8'h08);
      wt(3);
      `CHK("mfo user", 1'b0, mfo)
      wr(DMP_OFS_ALT_FUNC, 8'h06);
      wt(3);
      `CHK("mfo sel3", 1'b0, mfo)
      wr(DMP_OFS_MODEM_CTRL, 8'h00);
      wt(3);
      `CHK("mfo off", 1'b1, mfo)
      wr(DMP_OFS_ALT_FUNC, 8'h00);
      $display("test user output done");
   endtask
   task automatic t_baud();
      int hi;
      int rises;
      logic prev;
      hi = 0;
      rises = 0;
      wr(DMP_OFS_DIV_LO, 8'h04);
      wr(DMP_OFS_ALT_FUNC, 8'h02);
      wt(8);
      prev = mfo;
      for (int i = 0; i < 40; i++) begin
         wt(1);
         hi += int'(mfo === 1'b1);
         rises += int'(mfo === 1'b1 && prev === 1'b0);
         prev = mfo;
      end
      `CHK("baud high", 20, hi)
      `CHK("baud rises", 10, rises)
      wr(DMP_OFS_ALT_FUNC, 8'h00);
      wr(DMP_OFS_DIV_LO, 8'h01);
      $display("test baud clock done");
   endtask
   task automatic t_tx();
      wr(DMP_OFS_EVT_STAT, 8'hFF);
      wr(DMP_OFS_EVT_MASK, 8'h02);
      fork
         rm_u.grab(d, ok);
         wr(DMP_OFS_DATA, 8'hA5);
      join
      `CHK("tx byte", 8'hA5, d)
      `CHK("tx frame", 1'b1, ok)
      wt(20);
      `CHK("tx idle", 1'b1, tx)
      `CHK("irq set", 1'b1, irq)
      wr(DMP_OFS_EVT_STAT, 8'h02);
      wt(3);
      `CHK("irq clr", 1'b0, irq)
      wr(DMP_OFS_EVT_MASK, 8'h00);
      $display("test transmit done");
   endtask
   task automatic t_rx();
      wr(DMP_OFS_ALT_FUNC, 8'h04);
      wt(3);
      `CHK("rxrdy idle", 1'b1, mfo)
      rm_u.send(8'h3C, 1'b0);
      wt(8);
      `CHK("rxrdy on", 1'b0, mfo)
      rd(DMP_OFS_DATA, d);
      `CHK("rx byte", 8'h3C, d)
      wt(3);
      `CHK("rxrdy off", 1'b1, mfo)
      wr(DMP_OFS_ALT_FUNC, 8'h00);
      $display("test receive done");
   endtask
   // Inverted entry first: the pin idles high, then low once inversion is off
   task automatic t_ir();
      wr(DMP_OFS_FEATURE, 8'h04);
      wr(DMP_OFS_MODEM_CTRL, 8'h40);
      rm_u.set_mode(1'b1, 1'b1);
      wt(3);
      `CHK("ir tx idle", 1'b0, tx)
      rm_u.send(8'hC3, 1'b1);
      wt(8);
      rd(DMP_OFS_DATA, d);
      `CHK("ir inv byte", 8'hC3, d)
      wr(DMP_OFS_FEATURE, 8'h00);
      rm_u.set_mode(1'b1, 1'b0);
      wt(200);
      rm_u.send(8'h5A, 1'b1);
      wt(8);
      rd(DMP_OFS_DATA, d);
      `CHK("ir byte", 8'h5A, d)
      wr(DMP_OFS_MODEM_CTRL, 8'h00);
      rm_u.set_mode(1'b0, 1'b0);
      wt(40);
      $display("test infrared done");
   endtask
   task automatic t_cts();
      wr(DMP_OFS_INT_EN, 8'h80);
      wr(DMP_OFS_ENH_FEATURE, 8'h80);
      wr(DMP_OFS_EVT_STAT, 8'hFF);
      rm_u.set_cts(1'b1);
      wt(4);
      rd(DMP_OFS_EVT_STAT, d);
      `CHK("cts event", 1'b1, d[2])
      fork
         rm_u.grab(d, ok);
         begin
            wr(DMP_OFS_DATA, 8'h96);
            wt(60);
            `CHK("cts hold", 1'b1, tx)
            rm_u.set_cts(1'b0);
         end
      join
      `CHK("cts byte", 8'h96, d)
      `CHK("cts frame", 1'b1, ok)
      wr(DMP_OFS_ENH_FEATURE, 8'h00);
      wr(DMP_OFS_INT_EN, 8'h00);
      $display("test clear to send done");
   endtask
   task automatic t_rts();
      // Request asserted before any automatic use
      wr(DMP_OFS_MODEM_CTRL, 8'h03);
      wt(3);
      `CHK("rts on", 1'b0, rts_n)
      `CHK("dtr on", 1'b0, dtr_n)
      // Auto RTS switched on only once RTS is up
      wr(DMP_OFS_ENH_FEATURE, 8'h40);
      rm_u.send(8'h11, 1'b0);
      wt(8);
      `CHK("auto rts held", 1'b1, rts_n)
      rd(DMP_OFS_DATA, d);
      `CHK("auto rts byte", 8'h11, d)
      wt(3);
      `CHK("auto rts free", 1'b0, rts_n)
      wr(DMP_OFS_ENH_FEATURE, 8'h00);
      wr(DMP_OFS_FEATURE, 8'h08);
      wt(3);
      `CHK("dir idle", 1'b1, rts_n)
      fork
         rm_u.grab(d, ok);
         begin
            wr(DMP_OFS_DATA, 8'h0F);
            wt(40);
            `CHK("dir busy", 1'b0, rts_n)
         end
      join
      `CHK("dir byte", 8'h0F, d)
      wt(30);
      `CHK("dir done", 1'b1, rts_n)
      wr(DMP_OFS_ENH_MODE, 8'h08);
      wt(3);
      `CHK("dir pol", 1'b0, rts_n)
      wr(DMP_OFS_FEATURE, 8'h00);
      wr(DMP_OFS_ENH_MODE, 8'h00);
      wr(DMP_OFS_MODEM_CTRL, 8'h00);
      wt(3);
      `CHK("dtr off", 1'b1, dtr_n)
      $display("test request to send done");
   endtask
   task automatic t_modem();
      @(posedge ref_clk);
      dsr_n <= 1'b0;
      ri_n <= 1'b0;
      wt(3);
      rd(DMP_OFS_MODEM_STAT, d);
      `CHK("modem in", 3'h3, d[7:5])
      rm_u.send(8'h81, 1'b0);
      wt(8);
      rd(DMP_OFS_DATA, d);
      `CHK("rx unaffected", 8'h81, d)
      @(posedge ref_clk);
      dsr_n <= 1'b1;
      ri_n <= 1'b1;
      $display("test modem inputs done");
   endtask
   task automatic t_channel_select();
      @(posedge ref_clk);
      ch_sel <= 1'b0;
      wr(DMP_OFS_MODEM_CTRL, 8'h08);
      rd(DMP_OFS_MODEM_CTRL, d);
      `CHK("desel read", 8'h00, d)
      @(posedge ref_clk);
      ch_sel <= 1'b1;
      rd(DMP_OFS_MODEM_CTRL, d);
      `CHK("desel write", 8'h00, d)
      wr(DMP_OFS_ALT_FUNC, 8'h01);
      ch_sel <= 1'b0;
      wr(DMP_OFS_MODEM_CTRL, 8'h08);
      ch_sel <= 1'b1;
      rd(DMP_OFS_MODEM_CTRL, d);
      `CHK("broadcast", 8'h08, d)
      wr(DMP_OFS_ALT_FUNC, 8'h00);
      wr(DMP_OFS_MODEM_CTRL, 8'h00);
      rd(4'hC, d);
      `CHK("unmapped", 8'h00, d)
      $display("test channel select done");
   endtask
   initial begin
      repeat (8) @(posedge ref_clk);
      rst <= 1'b0;
      wt(2);
      t_reset();
      t_user();
      t_baud();
      t_tx();
      t_rx();
      t_ir();
      t_cts();
      t_rts();
      t_modem();
      t_channel_select();
      print_verdict();
   end
endmodule // testbench
`default_nettype wire
